// File: logic/qpos_pkg.sv
// Package of constants for the quadrature position and speed block.
package qpos_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LINES  = 8'h04;
    localparam logic [7:0] ADDR_KSCALE = 8'h08;
    localparam logic [7:0] ADDR_ASCALE = 8'h0C;
    localparam logic [7:0] ADDR_POS    = 8'h10;
    localparam logic [7:0] ADDR_IDXPOS = 8'h14;
    localparam logic [7:0] ADDR_DPULSE = 8'h18;
    localparam logic [7:0] ADDR_DTIME  = 8'h1C;
    localparam logic [7:0] ADDR_SPEED  = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_MASK   = 8'h28;
    // ==========================================================
    // Field positions
    localparam int CTRL_BYPASS = 0;
    localparam int CTRL_ZERO   = 1;
    localparam int CTRL_SPDEN  = 2;
    localparam int ST_IDXERR   = 0;
    localparam int ST_SPEED    = 1;
    // ==========================================================
    // Reset values
    localparam logic [15:0] LINES_RST  = 16'h0400;
    localparam logic [15:0] KSCALE_RST = 16'h0001;
    localparam logic [15:0] ASCALE_RST = 16'h0008;
    localparam logic [1:0]  MASK_RST   = 2'h0;
    // ==========================================================
    // Timing: speed period in microseconds, clock rate in MHz.
    localparam int unsigned CLK_MHZ      = 25;
    localparam int unsigned TB_PERIOD_US = 900;
    localparam int unsigned TB_CYCLES    = TB_PERIOD_US * CLK_MHZ;
    localparam logic [15:0] SPEED_MAX    = 16'h7FFF;
    localparam logic [5:0]  DIV_LAST     = 6'h1F;
    typedef enum logic {DIV_IDLE, DIV_RUN} div_st_t;
endpackage

// File: logic/quad_step.sv
// Quadrature phase decoder producing count steps and direction.
`timescale 1ns/1ns
`default_nettype none
module quad_step
    import qpos_pkg::*;
(
    input  wire logic hclk,    // System clock.
    input  wire logic hresetn, // Asynchronous reset, active low.
    input  wire logic pha,     // Encoder phase A.
    input  wire logic phb,     // Encoder phase B.
    output logic      step,    // One-cycle count pulse.
    output logic      up,      // Direction of that step.
    output logic      a_edge   // One-cycle pulse on any phase A edge.
);
    typedef struct packed {
        logic primed;
        logic pa;
        logic pb;
        logic step;
        logic up;
        logic aedge;
    } qs_t;
    qs_t r_r;
    qs_t r_nxt;

    // ==========================================================
    // Decode: one step per phase edge, direction from phase order.
    always_comb begin
        r_nxt = r_r;
        r_nxt.primed = 1'b1;
        r_nxt.pa = pha;
        r_nxt.pb = phb;
        // A simultaneous change of both phases is illegal and is dropped.
        r_nxt.step = r_r.primed && ((pha ^ r_r.pa) ^ (phb ^ r_r.pb));
        r_nxt.up = pha ^ r_r.pb;
        r_nxt.aedge = r_r.primed && (pha ^ r_r.pa);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign step = r_r.step;
    assign up = r_r.up;
    assign a_edge = r_r.aedge;
endmodule // quad_step
`default_nettype wire

// File: logic/speed_time_base.sv
// Periodic time base that triggers each speed calculation.
`timescale 1ns/1ns
`default_nettype none
module speed_time_base
    import qpos_pkg::*;
#(
    parameter int unsigned CYCLES = TB_CYCLES // Clock cycles per period.
) (
    input  wire logic hclk,    // System clock.
    input  wire logic hresetn, // Asynchronous reset, active low.
    output logic      tick     // One-cycle pulse once per period.
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } tb_t;
    tb_t r_r;
    tb_t r_nxt;

    // ==========================================================
    // Free-running divider; the pulse ends each period.
    always_comb begin
        r_nxt = r_r;
        r_nxt.tick = (r_r.cnt == 16'(CYCLES - 1));
        r_nxt.cnt = r_nxt.tick ? 16'h0000 : r_r.cnt + 16'h0001;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign tick = r_r.tick;

    tick_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tick |-> ##1 !tick[*2]) else $error("time base ticks too close");
endmodule // speed_time_base
`default_nettype wire

// File: logic/qpos_speed.sv
// Quadrature position and speed sensing with AHB-Lite register access.
`timescale 1ns/1ns
`default_nettype none
module qpos_speed
    import qpos_pkg::*;
#(
    parameter int unsigned TB_CYC = TB_CYCLES // Cycles per speed period.
) (
    input  wire logic        hclk,      // System clock.
    input  wire logic        hresetn,   // Asynchronous reset, active low.
    input  wire logic        hsel,      // Slave select.
    input  wire logic [31:0] haddr,     // Byte address.
    input  wire logic [1:0]  htrans,    // Transfer type.
    input  wire logic        hwrite,    // Write when high.
    input  wire logic [2:0]  hsize,     // Transfer size.
    input  wire logic [31:0] hwdata,    // Write data.
    input  wire logic        hready,    // Bus ready.
    output logic      [31:0] hrdata,    // Read data.
    output logic             hreadyout, // Slave ready.
    output logic             hresp,     // Always OKAY.
    input  wire logic        enc_a,     // Encoder phase A.
    input  wire logic        enc_b,     // Encoder phase B.
    input  wire logic        enc_idx,   // Encoder index pulse.
    output logic             irq,       // Level interrupt.
    output logic      [15:0] angle,     // Rotor angle, signed fraction.
    output logic      [15:0] speed      // Last computed speed.
);
    typedef struct packed {
        logic [15:0] pos;
        logic [15:0] idx_pos;
        logic        idx_seen;
        logic        idx_prev;
        logic [15:0] pcnt;
        logic [15:0] icnt;
        logic        half;
        logic [15:0] cap_p;
        logic [15:0] cap_i;
        logic [15:0] prev_p;
        logic [15:0] prev_i;
        logic [15:0] dpul;
        logic [15:0] dtim;
        logic        armed;
        logic [15:0] speed;
        logic [31:0] dvd;
        logic [16:0] rem;
        logic [5:0]  cnt;
        logic        neg;
        div_st_t     st;
        logic        bypass;
        logic        spd_en;
        logic [15:0] lines;
        logic [15:0] kscale;
        logic [15:0] ascale;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic        irq;
        logic [31:0] hrdata;
        logic        wr_pend;
        logic [7:0]  waddr;
        logic [15:0] angle;
        logic        rdy;
    } state_t;

    state_t r_r;
    state_t r_nxt;
    logic   step;
    logic   up;
    logic   a_edge;
    logic   tick;

    // ==========================================================
    // First stage decoder and the periodic trigger.
    quad_step u_dec (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pha     (enc_a),
        .phb     (enc_b),
        .step    (step),
        .up      (up),
        .a_edge  (a_edge)
    );

    speed_time_base #(.CYCLES(TB_CYC)) u_tb (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick)
    );

    // ==========================================================
    // Read multiplexer; unmapped offsets read as zero.
    function automatic logic [31:0] rd_mux(input state_t s, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            ADDR_CTRL:   d = {29'h0, s.spd_en, 1'b0, s.bypass};
            ADDR_LINES:  d = {16'h0, s.lines};
            ADDR_KSCALE: d = {16'h0, s.kscale};
            ADDR_ASCALE: d = {16'h0, s.ascale};
            ADDR_POS:    d = {16'h0, s.pos};
            ADDR_IDXPOS: d = {16'h0, s.idx_pos};
            ADDR_DPULSE: d = {16'h0, s.dpul};
            ADDR_DTIME:  d = {16'h0, s.dtim};
            ADDR_SPEED:  d = {16'h0, s.speed};
            ADDR_STATUS: d = {30'h0, s.status};
            ADDR_MASK:   d = {30'h0, s.mask};
            default:     d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    logic        ap;
    logic        zero_wr;
    logic        idx_rise;
    logic        capture;
    logic        trig;
    logic [15:0] limit;
    logic [15:0] dp;
    logic [15:0] mag;
    logic [16:0] tmp;
    logic [31:0] prod;
    logic [1:0]  st_set;
    logic [1:0]  st_clr;
    logic [15:0] sat;

    assign ap = hsel && htrans[1] && hready;
    assign zero_wr = r_r.wr_pend && (r_r.waddr == ADDR_CTRL) && hwdata[CTRL_ZERO];
    assign idx_rise = enc_idx && !r_r.idx_prev;
    assign trig = tick && r_r.spd_en;
    assign capture = a_edge && r_r.armed && !trig;
    assign limit = 16'((r_r.lines << 2) - 16'h0001);

    // ==========================================================
    // Next-state logic for the whole block.
    always_comb begin
        r_nxt = r_r;
        st_set = 2'h0;
        st_clr = 2'h0;
        dp = 16'h0000;
        mag = 16'h0000;
        tmp = 17'h00000;
        prod = 32'h0000_0000;
        sat = 16'h0000;
        r_nxt.rdy = 1'b1;
        r_nxt.idx_prev = enc_idx;

        // Bus slave: latch the address phase, act in the data phase.
        r_nxt.wr_pend = ap && hwrite;
        if (ap) begin
            r_nxt.waddr = haddr[7:0];
        end
        if (ap && !hwrite) begin
            r_nxt.hrdata = rd_mux(r_r, haddr[7:0]);
        end
        if (r_r.wr_pend) begin
            unique case (r_r.waddr)
                ADDR_CTRL: begin
                    r_nxt.bypass = hwdata[CTRL_BYPASS];
                    r_nxt.spd_en = hwdata[CTRL_SPDEN];
                end
                ADDR_LINES:  r_nxt.lines = hwdata[15:0];
                ADDR_KSCALE: r_nxt.kscale = hwdata[15:0];
                ADDR_ASCALE: r_nxt.ascale = hwdata[15:0];
                ADDR_STATUS: st_clr = hwdata[1:0];
                ADDR_MASK:   r_nxt.mask = hwdata[1:0];
                default: ;
            endcase
        end

        // Position counter fed by the decoder's step and direction.
        if (zero_wr) begin
            r_nxt.pos = 16'h0000;
            r_nxt.idx_seen = 1'b0;
        end else if (step) begin
            if (up) begin
                // Reload to zero on an up step taken at the compare limit.
                r_nxt.pos = (r_r.pos == limit) ? 16'h0000 : r_r.pos + 16'h0001;
            end else begin
                r_nxt.pos = (r_r.pos == -limit) ? 16'h0000 : r_r.pos - 16'h0001;
            end
        end

        // Index check; bypass skips it, so no index position is stored or compared.
        if (idx_rise && !r_r.bypass && !zero_wr) begin
            if (!r_r.idx_seen) begin
                r_nxt.idx_seen = 1'b1;
                r_nxt.idx_pos = r_r.pos;
            end else if (r_r.pos != r_r.idx_pos) begin
                st_set[ST_IDXERR] = 1'b1;
            end
        end

        // Scaled angle; the scale is 32768 over the counts per turn.
        prod = 32'($signed(r_r.pos) * $signed(r_r.ascale));
        r_nxt.angle = prod[15:0];

        // Pulse and interval timers; the half-rate interval keeps a
        // 900 us period near 11250 counts, under the signed limit.
        if (step) begin
            r_nxt.pcnt = up ? r_r.pcnt + 16'h0001 : r_r.pcnt - 16'h0001;
        end
        r_nxt.half = !r_r.half;
        if (r_r.half) begin
            r_nxt.icnt = r_r.icnt + 16'h0001;
        end

        // Capture both timers together on the first armed phase A edge.
        if (capture) begin
            r_nxt.cap_p = r_r.pcnt;
            r_nxt.cap_i = r_r.icnt;
            r_nxt.armed = 1'b0;
        end

        // Speed trigger: differences, save, re-arm, start the divide.
        if (trig) begin
            dp = r_r.cap_p - r_r.prev_p;
            r_nxt.dpul = dp;
            r_nxt.dtim = r_r.cap_i - r_r.prev_i;
            r_nxt.prev_p = r_r.cap_p;
            r_nxt.prev_i = r_r.cap_i;
            r_nxt.armed = 1'b1;
            r_nxt.neg = dp[15];
            mag = dp[15] ? -dp : dp;
            r_nxt.dvd = r_r.kscale * mag;
            r_nxt.rem = 17'h00000;
            r_nxt.cnt = 6'h00;
            if (r_nxt.dtim == 16'h0000) begin
                // No edge in the window: the shaft is treated as stopped.
                r_nxt.speed = 16'h0000;
                r_nxt.st = DIV_IDLE;
                st_set[ST_SPEED] = 1'b1;
            end else begin
                r_nxt.st = DIV_RUN;
            end
        end else begin
            unique case (r_r.st)
                DIV_IDLE: ;
                DIV_RUN: begin
                    // One quotient bit per cycle, 32 cycles per result.
                    tmp = {r_r.rem[15:0], r_r.dvd[31]};
                    if (tmp >= {1'b0, r_r.dtim}) begin
                        r_nxt.rem = tmp - {1'b0, r_r.dtim};
                        r_nxt.dvd = {r_r.dvd[30:0], 1'b1};
                    end else begin
                        r_nxt.rem = tmp;
                        r_nxt.dvd = {r_r.dvd[30:0], 1'b0};
                    end
                    r_nxt.cnt = r_r.cnt + 6'h01;
                    if (r_r.cnt == DIV_LAST) begin
                        // Saturate rather than wrap on an over-range quotient.
                        sat = (|r_nxt.dvd[31:15]) ? SPEED_MAX : r_nxt.dvd[15:0];
                        r_nxt.speed = r_r.neg ? -sat : sat;
                        r_nxt.st = DIV_IDLE;
                        st_set[ST_SPEED] = 1'b1;
                    end
                end
            endcase
        end

        // Sticky status: a set in the same cycle beats the clear.
        r_nxt.status = (r_r.status & ~st_clr) | st_set;
        r_nxt.irq = |(r_nxt.status & r_nxt.mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_r <= '0;
            r_r.lines <= LINES_RST;
            r_r.kscale <= KSCALE_RST;
            r_r.ascale <= ASCALE_RST;
            r_r.mask <= MASK_RST;
            r_r.st <= DIV_IDLE;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign hrdata = r_r.hrdata;
    assign hreadyout = r_r.rdy;
    assign hresp = 1'b0;
    assign irq = r_r.irq;
    assign angle = r_r.angle;
    assign speed = r_r.speed;

    // ==========================================================
    // Checks.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // A wrong compare limit or a lost up step shows up here before any register read does.
    pos_in_range_a: assert property ($signed(r_r.pos) <= $signed(limit)
        && $signed(r_r.pos) >= -$signed(limit)) else $error("position out of range");
    pos_step_up_a: assert property (step && up && !zero_wr && r_r.pos != limit
        |=> r_r.pos == $past(r_r.pos) + 16'h0001) else $error("position missed step");
    capture_disarm_a: assert property (capture |=> !r_r.armed
        && r_r.cap_i == $past(r_r.icnt)) else $error("capture did not disarm");
    capture_pair_a: assert property (capture |=> r_r.cap_p == $past(r_r.pcnt))
        else $error("pulse timer not captured with the interval");
    trig_rearm_a: assert property (trig |=> r_r.armed
        && r_r.prev_p == $past(r_r.cap_p)) else $error("trigger did not re-arm");
    // The expected difference is rebuilt from the two sampled captures on their own.
    diff_wrap_a: assert property (trig
        |=> r_r.dpul == 16'($past(r_r.cap_p) - $past(r_r.prev_p)))
        else $error("pulse difference wrong");
    interval_half_a: assert property ($changed(r_r.icnt) |=> $stable(r_r.icnt))
        else $error("interval timer too fast");
    index_error_a: assert property (idx_rise && !r_r.bypass && !zero_wr
        && r_r.idx_seen && r_r.pos != r_r.idx_pos |=> r_r.status[ST_IDXERR])
        else $error("index error not flagged");
    // Software clears the flag only by writing a one; nothing else may drop it.
    status_hold_a: assert property (r_r.status[ST_IDXERR]
        && !(r_r.wr_pend && r_r.waddr == ADDR_STATUS && hwdata[ST_IDXERR])
        |=> r_r.status[ST_IDXERR]) else $error("index error flag lost");
    zero_pos_a: assert property (zero_wr |=> r_r.pos == 16'h0000)
        else $error("position not cleared");
    bypass_idx_a: assert property (r_r.bypass && idx_rise |=> $stable(r_r.idx_pos))
        else $error("index sampled in bypass");
    divide_time_a: assert property ($rose(r_r.st == DIV_RUN) && !trig
        |-> ##[1:33] r_r.st == DIV_IDLE) else $error("divide took too long");

    // Covers show that the bench reaches each main scenario.
    capture_seen_c: cover property (capture);
    index_err_c: cover property (st_set[ST_IDXERR]);
    speed_done_c: cover property ($fell(r_r.st == DIV_RUN) && r_r.speed != 16'h0000);
    pos_wrap_c: cover property (step && up && r_r.pos == limit);
endmodule // qpos_speed
`default_nettype wire

// File: dv/enc_model.sv
// Behavioural incremental encoder with index, driving the position block's inputs.
`timescale 1ns/1ns
`default_nettype none
module enc_model (
    input  wire logic       hclk,    // System clock.
    input  wire logic       hresetn, // Reset, active low.
    input  wire logic       go,      // Keep stepping while high.
    input  wire logic       fwd,     // High steps with phase A leading.
    input  wire logic [7:0] gap,     // Idle cycles between two steps.
    input  wire logic       idx_go,  // Raise the index for one cycle.
    output logic            moved,   // A step lands at the coming edge.
    output logic            enc_a,   // Phase A.
    output logic            enc_b,   // Phase B.
    output var logic        enc_idx  // Index pulse.
);
    // ==========================================================
    // Quadrature state
    logic [1:0] ph_r;
    logic [7:0] cnt_r;

    // A Gray walk so only one phase ever changes per step; a slow gap keeps edges exact.
    assign moved = go && (cnt_r == 8'h00);
    assign enc_a = ph_r[0] ^ ph_r[1];
    assign enc_b = ph_r[1];

    // The phase counter steps at the edge where a step was announced.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_r    <= 2'h0;
            cnt_r   <= 8'h00;
            enc_idx <= 1'h0;
        end else begin
            enc_idx <= idx_go;
            if (moved) begin
                ph_r  <= fwd ? ph_r + 2'h1 : ph_r - 2'h1;
                cnt_r <= gap;
            end else if (go) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule // enc_model
`default_nettype wire

// File: dv/qpos_speed_tb.sv
// Self-checking bench for the quadrature position and speed block.
`timescale 1ns/1ns
`default_nettype none
module qpos_speed_tb
    import qpos_pkg::*;
;
    // ==========================================================
    // Signals and the table of ordinary cases
    localparam int unsigned TBC = 200; // A short period keeps the run brief.
    typedef struct packed {logic w; logic [3:0] n; logic dir; logic [7:0] a; logic [31:0] d;} row_t;
    logic        hclk      = 1'h0;
    logic        hresetn   = 1'h0;
    logic        hsel      = 1'h0;
    logic [31:0] haddr     = 32'h0;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'h0;
    logic [31:0] hwdata    = 32'h0;
    logic        go        = 1'h0;
    logic        fwd       = 1'h1;
    logic [7:0]  gap       = 8'h00;
    logic        idx_go    = 1'h0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, enc_a, enc_b, enc_idx, irq, moved;
    logic [15:0] angle, speed;
    int          mismatches = 0;
    int          cmp_count  = 0;
    int          cyc        = 0;
    row_t rows [17] = '{
        '{1'h0, 4'h0, 1'h0, ADDR_CTRL,   32'h0}, '{1'h0, 4'h0, 1'h0, ADDR_LINES,  32'h400},
        '{1'h0, 4'h0, 1'h0, ADDR_KSCALE, 32'h1}, '{1'h0, 4'h0, 1'h0, ADDR_ASCALE, 32'h8},
        '{1'h0, 4'h0, 1'h0, ADDR_POS,    32'h0}, '{1'h0, 4'h0, 1'h0, ADDR_IDXPOS, 32'h0},
        '{1'h0, 4'h0, 1'h0, ADDR_STATUS, 32'h0}, '{1'h0, 4'h0, 1'h0, ADDR_MASK,   32'h0},
        '{1'h0, 4'h0, 1'h0, 8'h40,       32'h0}, '{1'h1, 4'h0, 1'h0, ADDR_LINES,  32'h2},
        '{1'h1, 4'h0, 1'h0, ADDR_CTRL,   32'h2}, '{1'h0, 4'h7, 1'h1, ADDR_POS,    32'h7},
        '{1'h0, 4'h1, 1'h1, ADDR_POS,    32'h0}, '{1'h0, 4'h7, 1'h0, ADDR_POS,    32'hFFF9},
        '{1'h0, 4'h1, 1'h0, ADDR_POS,    32'h0}, '{1'h0, 4'h5, 1'h1, ADDR_POS,    32'h5},
        '{1'h0, 4'h7, 1'h0, ADDR_POS,    32'hFFFE}};

    // ==========================================================
    // Design, encoder and clock
    qpos_speed #(.TB_CYC(TBC)) qpos_speed_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx), .irq(irq), .angle(angle), .speed(speed));
    enc_model enc_model_inst (.hclk(hclk), .hresetn(hresetn), .go(go), .fwd(fwd), .gap(gap),
        .idx_go(idx_go), .moved(moved), .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx));

    // The clock toggles every half period of 20 ns.
    initial begin
        forever #20 hclk = ~hclk;
    end

    // A hang is cut short well after the expected sixteen hundred or so cycles.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 8000) begin
            mismatches++;
            close_out();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus transfer; the address phase is held until ready is sampled high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel   <= 1'h1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'h1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'h0, a, 32'h0, q);
    endtask

    // Counts announced steps so the stop lands after exactly n of them.
    task automatic move(input int n, input logic d);
        int k;
        k = 0;
        go  <= 1'h1;
        fwd <= d;
        while (k < n) begin
            @(posedge hclk);
            if (moved === 1'h1) k++;
        end
        go <= 1'h0;
        repeat (4) @(posedge hclk);
    endtask

    task automatic index_pulse();
        idx_go <= 1'h1;
        @(posedge hclk);
        idx_go <= 1'h0;
        repeat (5) @(posedge hclk);
    endtask

    // ==========================================================
    // Main sequence
    initial begin : main
        logic [31:0] v, t;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                if (rows[i].n != 4'h0) move(int'(rows[i].n), rows[i].dir);
                rd(rows[i].a, v);
                chk("table read", rows[i].d, v);
            end
        end
        chk("angle", 32'hFFF0, {16'h0, angle});
        chk("response", 32'h0, {31'h0, hresp});
        $display("test table done");
        // Index: store, same place again, then a slip of one count.
        wr(ADDR_CTRL, 32'h2);
        move(3, 1'h1);
        index_pulse();
        rd(ADDR_IDXPOS, v);
        chk("index position", 32'h3, v);
        move(8, 1'h1);
        index_pulse();
        rd(ADDR_STATUS, v);
        chk("status same place", 32'h0, v);
        move(1, 1'h1);
        index_pulse();
        rd(ADDR_STATUS, v);
        chk("status slipped", 32'h1, v);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(ADDR_MASK, 32'h1);
        repeat (3) @(posedge hclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(ADDR_STATUS, 32'h1);
        repeat (3) @(posedge hclk);
        rd(ADDR_STATUS, v);
        chk("status cleared", 32'h0, v);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(ADDR_CTRL, 32'h1);
        move(1, 1'h1);
        index_pulse();
        rd(ADDR_STATUS, v);
        chk("bypass status", 32'h0, v);
        wr(ADDR_CTRL, 32'h0);
        $display("test index done");
        // Speed: one step every 8 cycles gives 0.25 pulses per interval count.
        wr(ADDR_KSCALE, 32'h64);
        gap <= 8'h07;
        go  <= 1'h1;
        wr(ADDR_CTRL, 32'h4);
        repeat (4 * TBC) @(posedge hclk);
        rd(ADDR_SPEED, v);
        chk("speed forward", 32'h19, v);
        rd(ADDR_DPULSE, v);
        rd(ADDR_DTIME, t);
        chk("interval", {v[29:0], 2'h0}, t);
        rd(ADDR_STATUS, v);
        chk("speed ready", 32'h2, v & 32'h2);
        fwd <= 1'h0;
        repeat (3 * TBC + 40) @(posedge hclk);
        rd(ADDR_SPEED, v);
        chk("speed reverse", 32'hFFE7, v);
        chk("speed port", 32'hFFE7, {16'h0, speed});
        wr(ADDR_MASK, 32'h2);
        repeat (3) @(posedge hclk);
        chk("irq speed", 32'h1, {31'h0, irq});
        go <= 1'h0;
        $display("test speed done");
        // Reset in mid-run: outputs drop at once and registers return to reset values.
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        chk("reset irq", 32'h0, {31'h0, irq});
        chk("reset speed", 32'h0, {16'h0, speed});
        hresetn <= 1'h1;
        @(posedge hclk);
        rd(ADDR_LINES, v);
        chk("reset lines", {16'h0, LINES_RST}, v);
        rd(ADDR_POS, v);
        chk("reset position", 32'h0, v);
        rd(ADDR_SPEED, v);
        chk("reset speed reg", 32'h0, v);
        $display("test reset done");
        close_out();
    end
endmodule // qpos_speed_tb
`default_nettype wire
